// ### hw/opmode_pkg.sv
// Operating-mode and power-domain control: shared types and constants.
// Assumes a single 20 MHz clock and no software-visible register bus.
package opmode_pkg;

  // Main mode, ranked from highest to lowest consumption
  typedef enum logic [2:0] {
    MODE_RUN,
    MODE_SLEEP,
    MODE_STOP,
    MODE_STANDBY,
    MODE_SHUTDOWN
  } mode_t;

  // Sub-policy index within a mode
  localparam int POLICY_W = 2;
  localparam logic [1:0] POLICY_0 = 2'h0;
  localparam logic [1:0] POLICY_1 = 2'h1;
  localparam logic [1:0] POLICY_2 = 2'h2;

  // Per-function gating class
  typedef enum logic [2:0] {
    FN_ENABLED,
    FN_GATED,
    FN_OPTIONAL,
    FN_UNSUPPORTED,
    FN_OFF
  } fnclass_t;

  // Number of gated functions
  localparam int NUM_FN = 4;
  localparam int FN_HPD_PERIPH = 0;
  localparam int FN_LP_TIMERS = 1;
  localparam int FN_LP_OTHER = 2;
  localparam int FN_DMA = 3;

  // Reset-sequence duration on shutdown exit
  localparam int RESET_SEQ_NS = 1000;
  localparam int CLK_PERIOD_NS = 50;
  localparam int RESET_SEQ_CYC = (RESET_SEQ_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam logic [7:0] RESET_SEQ_LAST = 8'(RESET_SEQ_CYC - 1);

  // Software mode request
  typedef struct packed {
    logic valid;
    mode_t mode;
    logic [1:0] policy;
  } modereq_t;

  // Wake sources
  typedef struct packed {
    logic periphIrq;
    logic lpDomainIrq;
    logic extResetPin;
    logic debugActivity;
    logic ioLevelMatch;
  } wake_t;

  // Power and clock status towards the chip
  typedef struct packed {
    logic cpuRun;
    logic highPerfDomainOn;
    logic lowPowerDomainOn;
    logic coreRegulatorOn;
    logic sysOscOn;
    logic lowFreqOscOn;
    logic lpTimerClkOn;
    logic lpOtherClkOn;
  } pwrstat_t;

endpackage : opmode_pkg

// ### hw/reset_sync.sv
// Two-flip-flop reset release synchroniser.
// Assumes rstn is asynchronous and active low.
`timescale 1ns/1ps
module reset_sync (
  // Clock and raw reset
  input wire logic mclk,
  input wire logic rstn,
  // Synchronised reset
  output logic syncRstn
);

  logic stage1_ff; // First stage, read only by the second

  // Assert at once, release after two edges to avoid metastability
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      stage1_ff <= 1'b0;
      syncRstn <= 1'b0;
    end
    else
    begin
      stage1_ff <= 1'b1;
      syncRstn <= stage1_ff;
    end
  end

endmodule : reset_sync

// ### hw/operating_mode_power_domain_control.sv
// Operating-mode sequencer with power-domain and oscillator gating.
// Assumes synchronous inputs on mclk (20 MHz) and that software enables
// for optional functions are steady while a mode is being entered.
// Behaviour
// - five modes: run, sleep, stop, standby, shutdown
// - CPU executes only in run mode
// - peripheral interrupt wakes sleep to run; low-power domain interrupt wakes sleep/stop/standby
// - shutdown: regulator off; reset/debug/IO wake only
// - run..standby each have selectable sub-policies
// - high-perf domain on only in run, sleep
// - low-power domain on except shutdown
// - gated function keeps configuration, clock gated
// - fully off function loses configuration
// - optional function stays active if software enabled
// - unsupported function not gated automatically
// - system oscillator policy per mode and sub-policy
// - standby1 clocks only the low-power timers and the DMA function
`timescale 1ns/1ps
module operating_mode_power_domain_control #(
  parameter int SEQ_CYCLES = opmode_pkg::RESET_SEQ_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Software mode request and optional enables
  input wire opmode_pkg::modereq_t modeReq,
  input wire logic [opmode_pkg::NUM_FN-1:0] fnSwEnable,
  input wire logic stop0OscKeep,
  // Wake sources
  input wire opmode_pkg::wake_t wake,
  // Status outputs
  output opmode_pkg::mode_t curMode,
  output logic [1:0] curPolicy,
  output opmode_pkg::pwrstat_t pwrStat,
  output logic [opmode_pkg::NUM_FN-1:0] fnClkEn,
  output logic [opmode_pkg::NUM_FN-1:0] fnCfgRetainN,
  output logic resetSeqBusy
);

  logic syncRstn; // Synchronised reset

  // Reset release through two flip-flops
  reset_sync u_reset_sync (
    .mclk(mclk),
    .rstn(rstn),
    .syncRstn(syncRstn)
  );

  // Mode state and reset-sequence counter
  opmode_pkg::mode_t mode_ff, nxt_mode;
  logic [1:0] policy_ff, nxt_policy;
  logic [7:0] seqCnt_ff, nxt_seqCnt;
  logic seqBusy_ff, nxt_seqBusy;
  opmode_pkg::pwrstat_t stat_ff, nxt_stat;
  logic [opmode_pkg::NUM_FN-1:0] clkEn_ff, nxt_clkEn;
  logic [opmode_pkg::NUM_FN-1:0] cfgLoss_ff, nxt_cfgLoss;

  // Gating class of a function in a mode and policy
  function automatic opmode_pkg::fnclass_t fn_class(
    input opmode_pkg::mode_t m, input logic [1:0] p, input int fn);
    opmode_pkg::fnclass_t c;
    c = opmode_pkg::FN_OFF;
    case (m)
      opmode_pkg::MODE_RUN, opmode_pkg::MODE_SLEEP:
        c = opmode_pkg::FN_OPTIONAL;
      opmode_pkg::MODE_STOP, opmode_pkg::MODE_STANDBY:
      begin
        if (fn == opmode_pkg::FN_HPD_PERIPH)
          c = opmode_pkg::FN_GATED;
        else if (fn == opmode_pkg::FN_DMA)
          c = opmode_pkg::FN_UNSUPPORTED;
        else if (m == opmode_pkg::MODE_STANDBY && p == opmode_pkg::POLICY_1
                 && fn == opmode_pkg::FN_LP_OTHER)
          c = opmode_pkg::FN_GATED;
        else
          c = opmode_pkg::FN_OPTIONAL;
      end
      default:
        c = opmode_pkg::FN_OFF;
    endcase
    return c;
  endfunction : fn_class

  // System oscillator policy
  function automatic logic osc_on(
    input opmode_pkg::mode_t m, input logic [1:0] p, input logic keep);
    logic on;
    on = 1'b0;
    case (m)
      opmode_pkg::MODE_RUN, opmode_pkg::MODE_SLEEP:
        on = (p != opmode_pkg::POLICY_2);
      opmode_pkg::MODE_STOP:
        on = (p == opmode_pkg::POLICY_1) ||
             (p == opmode_pkg::POLICY_0 && keep);
      default:
        on = 1'b0;
    endcase
    return on;
  endfunction : osc_on

  // Mode transitions, wake handling and shutdown-exit sequence
  always_comb
  begin
    nxt_mode = mode_ff;
    nxt_policy = policy_ff;
    nxt_seqCnt = seqCnt_ff;
    nxt_seqBusy = seqBusy_ff;
    if (seqBusy_ff)
    begin
      // Hold the CPU and mode changes until the reset sequence has finished
      if (seqCnt_ff == 8'(SEQ_CYCLES - 1))
        nxt_seqBusy = 1'b0;
      else
        nxt_seqCnt = seqCnt_ff + 8'h01;
    end
    else
    begin
      case (mode_ff)
        opmode_pkg::MODE_SHUTDOWN:
        begin
          // Only reset pin, debug or IO level match leave shutdown
          if (wake.extResetPin || wake.debugActivity || wake.ioLevelMatch)
          begin
            nxt_mode = opmode_pkg::MODE_RUN;
            nxt_policy = opmode_pkg::POLICY_0;
            nxt_seqBusy = 1'b1;
            nxt_seqCnt = 8'h00;
          end
        end
        opmode_pkg::MODE_SLEEP:
        begin
          if (wake.periphIrq || wake.lpDomainIrq)
            nxt_mode = opmode_pkg::MODE_RUN;
        end
        opmode_pkg::MODE_STOP, opmode_pkg::MODE_STANDBY:
        begin
          // Only the low-power domain is alive to raise an interrupt
          if (wake.lpDomainIrq)
            nxt_mode = opmode_pkg::MODE_RUN;
        end
        opmode_pkg::MODE_RUN:
        begin
          // Only running code can request a new mode
          if (modeReq.valid)
          begin
            nxt_mode = modeReq.mode;
            nxt_policy = (modeReq.policy > opmode_pkg::POLICY_2) ?
                         opmode_pkg::POLICY_0 : modeReq.policy;
          end
        end
        default:
          nxt_mode = opmode_pkg::MODE_RUN;
      endcase
    end
  end

  // Power, oscillator and per-function clock outputs for next state
  always_comb
  begin
    opmode_pkg::fnclass_t c;
    c = opmode_pkg::FN_OFF;
    nxt_stat.cpuRun = (nxt_mode == opmode_pkg::MODE_RUN)
                      && !nxt_seqBusy;
    nxt_stat.highPerfDomainOn = (nxt_mode == opmode_pkg::MODE_RUN) ||
                      (nxt_mode == opmode_pkg::MODE_SLEEP);
    nxt_stat.lowPowerDomainOn =
      (nxt_mode != opmode_pkg::MODE_SHUTDOWN);
    nxt_stat.coreRegulatorOn =
      (nxt_mode != opmode_pkg::MODE_SHUTDOWN);
    nxt_stat.sysOscOn = osc_on(nxt_mode, nxt_policy, stop0OscKeep);
    nxt_stat.lowFreqOscOn = (nxt_mode != opmode_pkg::MODE_SHUTDOWN);
    for (int i = 0; i < opmode_pkg::NUM_FN; i++)
    begin
      c = fn_class(nxt_mode, nxt_policy, i);
      case (c)
        opmode_pkg::FN_OPTIONAL:
          nxt_clkEn[i] = fnSwEnable[i];
        opmode_pkg::FN_UNSUPPORTED:
          nxt_clkEn[i] = fnSwEnable[i];
        opmode_pkg::FN_ENABLED:
          nxt_clkEn[i] = 1'b1;
        default:
          nxt_clkEn[i] = 1'b0;
      endcase
      nxt_cfgLoss[i] = (c == opmode_pkg::FN_OFF);
    end
    nxt_stat.lpTimerClkOn = nxt_clkEn[opmode_pkg::FN_LP_TIMERS];
    nxt_stat.lpOtherClkOn = nxt_clkEn[opmode_pkg::FN_LP_OTHER];
  end

  // State registers
  always_ff @(posedge mclk or negedge syncRstn)
  begin
    if (!syncRstn)
    begin
      mode_ff <= opmode_pkg::MODE_RUN;
      policy_ff <= opmode_pkg::POLICY_0;
      seqCnt_ff <= 8'h00;
      seqBusy_ff <= 1'b0;
      stat_ff <= '0;
      clkEn_ff <= '0;
      cfgLoss_ff <= '0;
    end
    else
    begin
      mode_ff <= nxt_mode;
      policy_ff <= nxt_policy;
      seqCnt_ff <= nxt_seqCnt;
      seqBusy_ff <= nxt_seqBusy;
      stat_ff <= nxt_stat;
      clkEn_ff <= nxt_clkEn;
      cfgLoss_ff <= nxt_cfgLoss;
    end
  end

  assign curMode = mode_ff;
  assign curPolicy = policy_ff;
  assign pwrStat = stat_ff;
  assign fnClkEn = clkEn_ff;
  assign fnCfgRetainN = cfgLoss_ff;
  assign resetSeqBusy = seqBusy_ff;

  // Checks
  property p_cpu_run_only;
    @(posedge mclk) disable iff (!syncRstn)
    stat_ff.cpuRun |-> mode_ff == opmode_pkg::MODE_RUN;
  endproperty
  a_cpu_run_only: assert property (p_cpu_run_only)
    else $error("CPU runs outside run mode");

  property p_wake_sleep;
    @(posedge mclk) disable iff (!syncRstn)
    (mode_ff == opmode_pkg::MODE_SLEEP && !seqBusy_ff && wake.periphIrq)
      |=> mode_ff == opmode_pkg::MODE_RUN;
  endproperty
  a_wake_sleep: assert property (p_wake_sleep)
    else $error("Interrupt did not wake from sleep");

  property p_shutdown_exit;
    @(posedge mclk) disable iff (!syncRstn)
    (mode_ff == opmode_pkg::MODE_SHUTDOWN && !seqBusy_ff &&
     !wake.extResetPin && !wake.debugActivity && !wake.ioLevelMatch)
      |=> mode_ff == opmode_pkg::MODE_SHUTDOWN;
  endproperty
  a_shutdown_exit: assert property (p_shutdown_exit)
    else $error("Shutdown left without allowed source");

  property p_hpd;
    @(posedge mclk) disable iff (!syncRstn)
    $past(syncRstn) |-> stat_ff.highPerfDomainOn == ($past(nxt_mode)
      == opmode_pkg::MODE_RUN || $past(nxt_mode) == opmode_pkg::MODE_SLEEP);
  endproperty
  a_hpd: assert property (p_hpd)
    else $error("High-performance domain state wrong");

  property p_lpd;
    @(posedge mclk) disable iff (!syncRstn)
    (mode_ff == opmode_pkg::MODE_STANDBY) |-> stat_ff.lowPowerDomainOn;
  endproperty
  a_lpd: assert property (p_lpd)
    else $error("Low-power domain off in standby");

  property p_osc_stop2;
    @(posedge mclk) disable iff (!syncRstn)
    (mode_ff == opmode_pkg::MODE_STOP && policy_ff == opmode_pkg::POLICY_2)
      |-> !stat_ff.sysOscOn;
  endproperty
  a_osc_stop2: assert property (p_osc_stop2)
    else $error("Oscillator on in stop2");

  property p_standby1;
    @(posedge mclk) disable iff (!syncRstn)
    (mode_ff == opmode_pkg::MODE_STANDBY && policy_ff == opmode_pkg::POLICY_1)
      |-> !stat_ff.lpOtherClkOn;
  endproperty
  a_standby1: assert property (p_standby1)
    else $error("Other low-power peripherals clocked in standby1");

  property p_seq;
    @(posedge mclk) disable iff (!syncRstn)
    $rose(seqBusy_ff) |-> !stat_ff.cpuRun [*2];
  endproperty
  a_seq: assert property (p_seq)
    else $error("CPU ran during reset sequence");

  property p_cfg_off;
    @(posedge mclk) disable iff (!syncRstn)
    (mode_ff == opmode_pkg::MODE_SHUTDOWN) |-> (&fnCfgRetainN) && !fnClkEn[0];
  endproperty
  a_cfg_off: assert property (p_cfg_off)
    else $error("Configuration kept in shutdown");

  c_sleep: cover property (@(posedge mclk) disable iff (!syncRstn)
    mode_ff == opmode_pkg::MODE_SLEEP ##1 mode_ff == opmode_pkg::MODE_RUN);
  c_standby: cover property (@(posedge mclk) disable iff (!syncRstn)
    mode_ff == opmode_pkg::MODE_STANDBY ##1 mode_ff == opmode_pkg::MODE_RUN);
  c_shutdown: cover property (@(posedge mclk) disable iff (!syncRstn)
    $fell(seqBusy_ff));

endmodule : operating_mode_power_domain_control

// ### bench/operating_mode_power_domain_control_tb.sv
// Self-checking bench for the operating-mode and power-domain controller.
// Assumes the package is compiled first; inputs move on falling mclk.
`timescale 1ns/1ps
module operating_mode_power_domain_control_tb;
  // Short reset sequence keeps the run brief
  localparam int SEQ = 2;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  opmode_pkg::modereq_t modeReq = '0;
  logic [3:0] fnSwEnable = 4'hF;
  logic stop0OscKeep = 1'b1;
  opmode_pkg::wake_t wake = '0;
  opmode_pkg::mode_t curMode;
  logic [1:0] curPolicy;
  opmode_pkg::pwrstat_t pwrStat;
  logic [3:0] fnClkEn;
  logic [3:0] fnCfgRetainN;
  logic resetSeqBusy;
  int badCount = 0;
  int checks = 0;

  // 50 ns period
  always #25 mclk = ~mclk;

  operating_mode_power_domain_control #(.SEQ_CYCLES(SEQ)) i_dut (
    .mclk(mclk), .rstn(rstn), .modeReq(modeReq),
    .fnSwEnable(fnSwEnable), .stop0OscKeep(stop0OscKeep), .wake(wake),
    .curMode(curMode), .curPolicy(curPolicy), .pwrStat(pwrStat),
    .fnClkEn(fnClkEn), .fnCfgRetainN(fnCfgRetainN),
    .resetSeqBusy(resetSeqBusy)
  );

  // Verdict and end of run, shared with every timeout
  task automatic results;
    $display("checks %0d mismatches %0d", checks, badCount);
    if (badCount == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results

  // Four-state compare; an unknown only matches an unknown
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      badCount++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  // One-cycle request; outputs settled when the task returns
  task automatic req(input opmode_pkg::mode_t m, input logic [1:0] p);
    @(negedge mclk);
    modeReq = {1'b1, m, p};
    @(negedge mclk);
    modeReq.valid = 1'b0;
  endtask : req

  // One-cycle wake pulse
  task automatic wk(input logic [4:0] w);
    @(negedge mclk);
    wake = w;
    @(negedge mclk);
    wake = '0;
  endtask : wk

  // Expected {cpu, fast domain, slow domain, regulator, system_oscillator, low_freq_oscillator}
  function automatic logic [7:0] expStat(input opmode_pkg::mode_t m,
                                          input logic [1:0] p);
    logic osc;
    logic alive;
    alive = (m != opmode_pkg::MODE_SHUTDOWN);
    if (m == opmode_pkg::MODE_RUN || m == opmode_pkg::MODE_SLEEP)
      osc = (p != 2'h2);
    else if (m == opmode_pkg::MODE_STOP)
      osc = (p == 2'h0) ? stop0OscKeep : (p == 2'h1);
    else
      osc = 1'b0;
    return {2'h0, m == opmode_pkg::MODE_RUN, alive && m <= 3'h1, alive,
            alive, osc, alive};
  endfunction : expStat

  // Every mode and sub-policy above shutdown except standby2, with wake back to run
  task automatic testModes;
    opmode_pkg::mode_t ms[11] = '{opmode_pkg::MODE_RUN,
      opmode_pkg::MODE_RUN, opmode_pkg::MODE_RUN, opmode_pkg::MODE_SLEEP,
      opmode_pkg::MODE_SLEEP, opmode_pkg::MODE_SLEEP, opmode_pkg::MODE_STOP,
      opmode_pkg::MODE_STOP, opmode_pkg::MODE_STOP,
      opmode_pkg::MODE_STANDBY, opmode_pkg::MODE_STANDBY};
    logic [1:0] ps[11] = '{2'h1, 2'h2, 2'h0, 2'h0, 2'h1, 2'h2, 2'h0,
                           2'h1, 2'h2, 2'h0, 2'h1};
    for (int i = 0; i < 11; i++)
    begin
      req(ms[i], ps[i]);
      chk(8'(curMode), 8'(ms[i]));
      chk(8'(curPolicy), 8'(ps[i]));
      chk(8'(pwrStat[7:2]), expStat(ms[i], ps[i]));
      if (ms[i] == opmode_pkg::MODE_SLEEP)
      begin
        // Requests are ignored outside run
        req(opmode_pkg::MODE_STOP, 2'h0);
        chk(8'(curMode), 8'(opmode_pkg::MODE_SLEEP));
        wk(5'h10);
        chk(8'(curMode), 8'(opmode_pkg::MODE_RUN));
      end
      else if (ms[i] != opmode_pkg::MODE_RUN)
      begin
        chk(8'(fnCfgRetainN), 8'h00);
        if (ms[i] == opmode_pkg::MODE_STANDBY && ps[i] == 2'h1)
        begin
          chk(8'(fnClkEn), 8'h0A);
          chk(8'(pwrStat[1:0]), 8'h02);
        end
        else
          chk(8'(fnClkEn), 8'h0E);
        // A fast-domain interrupt cannot wake the deep modes
        wk(5'h10);
        chk(8'(curMode), 8'(ms[i]));
        wk(5'h08);
        chk(8'(curMode), 8'(opmode_pkg::MODE_RUN));
      end
    end
    $display("test modes done");
  endtask : testModes

  // Optional functions follow the software enables in run
  task automatic testEnables;
    @(negedge mclk);
    fnSwEnable = 4'h5;
    repeat (2) @(negedge mclk);
    chk(8'(fnClkEn), 8'h05);
    fnSwEnable = 4'hF;
    $display("test enables done");
  endtask : testEnables

  // Out-of-range policy and stop0 with the oscillator released
  task automatic testOptions;
    // Policy 3 is not defined and falls back to policy 0
    req(opmode_pkg::MODE_RUN, 2'h3);
    chk(8'(curPolicy), 8'h00);
    stop0OscKeep = 1'b0;
    req(opmode_pkg::MODE_STOP, 2'h0);
    chk(8'(pwrStat.sysOscOn), 8'h00);
    chk(8'(pwrStat[7:2]), expStat(opmode_pkg::MODE_STOP, 2'h0));
    wk(5'h08);
    chk(8'(curMode), 8'(opmode_pkg::MODE_RUN));
    stop0OscKeep = 1'b1;
    $display("test options done");
  endtask : testOptions

  // Shutdown entry, refused wake and exit by each allowed source
  task automatic testShutdown;
    logic [4:0] src[3] = '{5'h04, 5'h02, 5'h01};
    int n;
    for (int i = 0; i < 3; i++)
    begin
      req(opmode_pkg::MODE_SHUTDOWN, 2'h0);
      chk(8'(pwrStat), 8'h00);
      chk(8'(fnCfgRetainN), 8'h0F);
      chk(8'(fnClkEn), 8'h00);
      wk(5'h18);
      chk(8'(curMode), 8'(opmode_pkg::MODE_SHUTDOWN));
      wk(src[i]);
      chk(8'(curMode), 8'(opmode_pkg::MODE_RUN));
      n = 0;
      // Processor held off for the whole reset sequence
      while (resetSeqBusy === 1'b1 && n < 50)
      begin
        chk(8'(pwrStat.cpuRun), 8'h00);
        n++;
        @(negedge mclk);
      end
      if (n == 50)
      begin
        badCount++;
        results();
      end
      chk(8'(n), 8'(SEQ));
      chk(8'(pwrStat.cpuRun), 8'h01);
      chk(8'(curPolicy), 8'h00);
      @(negedge mclk);
      chk(8'(pwrStat.cpuRun), 8'h01);
    end
    $display("test shutdown done");
  endtask : testShutdown

  // Main sequence
  initial
  begin
    repeat (2) @(negedge mclk);
    rstn = 1'b1;
    repeat (3) @(negedge mclk);
    chk(8'(curMode), 8'(opmode_pkg::MODE_RUN));
    chk(8'(pwrStat[7:2]), expStat(opmode_pkg::MODE_RUN, 2'h0));
    testModes();
    testEnables();
    testOptions();
    testShutdown();
    results();
  end
endmodule : operating_mode_power_domain_control_tb
